// file: logic/fpkl_pkg.sv
// Summary of operation
// - exactly one trend lamp lit: rising, level or falling with setpoint direction
// - both process event lamps follow their process-value events
// - four timed event lamps follow their time events
// - alarm_one_lamp follows instrument alarm one on and off
// - status lamps show program, reset, hold, local and manual states
// - second-loop display, second manual and secondary link lamps stay off
// - error condition replaces process-value readout with red error code
// - short register_key switches or commits; over 3 s toggles operating and main menu
// - view_back_key advances operating view, elsewhere goes one display back
// - at most three view_back_key presses reach the operating display
// - down decrements, up increments the selected value on setting displays
// - holding up or down progressively raises the change rate
// - on main menu or submenu, up and down step between menus
// - pattern_number_key accepted only when stopped on an operating display
// - run key held over 2 s on an operating display starts controller
// - reset key held over 2 s on an operating display stops controller
// - mode key opens selection of hold, advance, local, auto, manual
package fpkl_pkg;
   localparam int CLK_HZ          = 40_000_000;
   localparam int CYC_PER_MS      = CLK_HZ / 1000;
   localparam int DEBOUNCE_MS     = 10;
   localparam int REG_LONG_MS     = 3000;
   localparam int RUN_LONG_MS     = 2000;
   localparam int REPEAT_START_MS = 500;
   localparam int REPEAT_SLOW_MS  = 200;
   localparam int REPEAT_FAST_MS  = 25;
   localparam int STEPS_PER_STAGE = 8;
   localparam int OPER_VIEWS      = 4;
   localparam int MENU_ITEMS      = 8;

   localparam int NUM_KEYS = 8;
   localparam int KEY_REG  = 0;
   localparam int KEY_VIEW = 1;
   localparam int KEY_UP   = 2;
   localparam int KEY_DOWN = 3;
   localparam int KEY_PAT  = 4;
   localparam int KEY_RUN  = 5;
   localparam int KEY_RST  = 6;
   localparam int KEY_MODE = 7;

   typedef enum logic [2:0] {VIEW_BACK_KEY_OPER, VIEW_BACK_KEY_MAIN, VIEW_BACK_KEY_SUB, VIEW_BACK_KEY_PARAM, VIEW_BACK_KEY_MODE} fpkl_view_back_key_e;
   typedef enum logic [1:0] {TREND_RISE, TREND_LEVEL, TREND_FALL} fpkl_trend_e;
   typedef enum logic [2:0] {MODE_HOLD, MODE_ADVANCE, MODE_LOCAL, MODE_AUTO,
                             MODE_MANUAL} fpkl_mode_e;

   typedef struct packed {
      logic [1:0] trend;
      logic [1:0] pv_event;
      logic [3:0] time_event;
      logic       alarm_one;
      logic       program_mode;
      logic       reset_mode;
      logic       hold_mode;
      logic       local_mode;
      logic       manual_mode;
      logic       error_active;
      logic       running;
   } fpkl_status_s;

   typedef struct packed {
      logic rising_lamp;
      logic level_lamp;
      logic falling_lamp;
      logic process_event_one_lamp;
      logic process_event_two_lamp;
      logic [3:0] timed_event_lamp;
      logic alarm_one_lamp;
      logic program_mode_lamp;
      logic reset_mode_lamp;
      logic hold_mode_lamp;
      logic internal_sp_lamp;
      logic manual_mode_lamp;
      logic second_pv_lamp;
      logic second_manual_lamp;
      logic secondary_link_lamp;
      logic pv_error_red;
   } fpkl_lamps_s;

   typedef struct packed {
      logic       start_pulse;
      logic       stop_pulse;
      logic       param_switch_pulse;
      logic       param_commit_pulse;
      logic       value_inc_pulse;
      logic       value_dec_pulse;
      logic       pattern_step_pulse;
      logic       mode_commit_pulse;
   } fpkl_action_s;
endpackage

// file: logic/fpkl_panel.sv
`timescale 1ns/1ps
module fpkl_panel
   import fpkl_pkg::*;
#(
   parameter int DEB_CYC       = DEBOUNCE_MS * CYC_PER_MS,
   parameter int REG_LONG_CYC  = REG_LONG_MS * CYC_PER_MS,
   // run and reset thresholds keep their ratio to the register threshold
   parameter int RUN_LONG_CYC  = int'((longint'(REG_LONG_CYC) * RUN_LONG_MS) / REG_LONG_MS),
   parameter int REP_START_CYC = REPEAT_START_MS * CYC_PER_MS,
   parameter int REP_SLOW_CYC  = REPEAT_SLOW_MS * CYC_PER_MS,
   parameter int REP_FAST_CYC  = REP_SLOW_CYC * REPEAT_FAST_MS / REPEAT_SLOW_MS,
   parameter int NUM_VIEWS     = OPER_VIEWS,
   parameter int NUM_MENUS     = MENU_ITEMS
) (
   input  wire logic                  clock,
   input  wire logic                  rst,
   input  wire logic [NUM_KEYS-1:0]   keys_raw,
   input  wire fpkl_status_s          status,
   output fpkl_lamps_s                lamps,
   output fpkl_action_s               actions,
   output fpkl_view_back_key_e                 display,
   output logic [7:0]                 oper_view,
   output logic [7:0]                 menu_index,
   output fpkl_mode_e                 mode_choice
);
   logic [NUM_KEYS-1:0] sync1_reg;
   logic [NUM_KEYS-1:0] sync2_reg;
   logic [NUM_KEYS-1:0] key_down;
   logic [NUM_KEYS-1:0] key_prev_reg;
   logic [NUM_KEYS-1:0] press;
   logic [NUM_KEYS-1:0] letgo;
   logic [31:0]         hold_cnt [NUM_KEYS];

   // keys are panel contacts, asynchronous to the clock
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= keys_raw;
         sync2_reg <= sync1_reg;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_KEYS; g++) begin : key_gen
         logic [31:0] deb_cnt_reg;
         logic        stable_reg;
         logic [31:0] hold_cnt_reg;
         // contact must sit still a full debounce span before it counts
         always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
               deb_cnt_reg <= 32'h0000_0000;
               stable_reg  <= 1'b0;
            end else if (sync2_reg[g] == stable_reg) begin
               deb_cnt_reg <= 32'h0000_0000;
            end else if (deb_cnt_reg >= 32'(DEB_CYC - 1)) begin
               deb_cnt_reg <= 32'h0000_0000;
               stable_reg  <= sync2_reg[g];
            end else begin
               deb_cnt_reg <= deb_cnt_reg + 32'h0000_0001;
            end
         end
         // saturates so a key held for hours never wraps into a second long press
         always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
               hold_cnt_reg <= 32'h0000_0000;
            end else if (!stable_reg) begin
               hold_cnt_reg <= 32'h0000_0000;
            end else if (hold_cnt_reg != 32'hFFFF_FFFF) begin
               hold_cnt_reg <= hold_cnt_reg + 32'h0000_0001;
            end
         end
         assign key_down[g] = stable_reg;
         assign hold_cnt[g] = hold_cnt_reg;
      end
   endgenerate

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         key_prev_reg <= '0;
      end else begin
         key_prev_reg <= key_down;
      end
   end
   assign press   = key_down & ~key_prev_reg;
   assign letgo   = ~key_down & key_prev_reg;

   // long actions fire on the single cycle the count crosses the threshold
   logic reg_long;
   logic reg_short;
   logic run_long;
   logic rst_long;
   logic in_oper;
   assign in_oper   = (display == VIEW_BACK_KEY_OPER);
   assign reg_long  = key_down[KEY_REG] && hold_cnt[KEY_REG] == 32'(REG_LONG_CYC);
   assign reg_short = letgo[KEY_REG] && hold_cnt[KEY_REG] < 32'(REG_LONG_CYC);
   assign run_long  = key_down[KEY_RUN] && hold_cnt[KEY_RUN] == 32'(RUN_LONG_CYC);
   assign rst_long  = key_down[KEY_RST] && hold_cnt[KEY_RST] == 32'(RUN_LONG_CYC);

   // auto-repeat for up and down; both held together is ignored
   logic        up_only;
   logic        down_only;
   logic        rep_step;
   logic [31:0] rep_timer_reg;
   logic [31:0] rep_interval_reg;
   logic [7:0]  rep_count_reg;
   assign up_only   = key_down[KEY_UP] && !key_down[KEY_DOWN];
   assign down_only = key_down[KEY_DOWN] && !key_down[KEY_UP];
   assign rep_step  = ((press[KEY_UP] && !key_down[KEY_DOWN])
                      || (press[KEY_DOWN] && !key_down[KEY_UP])
                      || ((up_only || down_only) && rep_timer_reg == 32'h0000_0001));

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rep_timer_reg    <= 32'h0000_0000;
         rep_interval_reg <= 32'(REP_SLOW_CYC);
         rep_count_reg    <= 8'h00;
      end else if (!(up_only || down_only)) begin
         rep_timer_reg    <= 32'h0000_0000;
         rep_interval_reg <= 32'(REP_SLOW_CYC);
         rep_count_reg    <= 8'h00;
      end else if (press[KEY_UP] || press[KEY_DOWN]) begin
         rep_timer_reg    <= 32'(REP_START_CYC);
         rep_interval_reg <= 32'(REP_SLOW_CYC);
         rep_count_reg    <= 8'h00;
      end else if (rep_timer_reg == 32'h0000_0001) begin
         rep_timer_reg <= rep_interval_reg;
         // halve the interval each stage, floored at the fast rate
         if (rep_count_reg == 8'(STEPS_PER_STAGE - 1)) begin
            rep_count_reg <= 8'h00;
            if ((rep_interval_reg >> 1) > 32'(REP_FAST_CYC)) begin
               rep_interval_reg <= rep_interval_reg >> 1;
            end else begin
               rep_interval_reg <= 32'(REP_FAST_CYC);
            end
         end else begin
            rep_count_reg <= rep_count_reg + 8'h01;
         end
      end else if (rep_timer_reg != 32'h0000_0000) begin
         rep_timer_reg <= rep_timer_reg - 32'h0000_0001;
      end
   end

   // display navigation
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         display <= VIEW_BACK_KEY_OPER;
      end else if (reg_long) begin
         display <= in_oper ? VIEW_BACK_KEY_MAIN : VIEW_BACK_KEY_OPER;
      end else if (press[KEY_VIEW]) begin
         unique case (display)
            VIEW_BACK_KEY_OPER:  display <= VIEW_BACK_KEY_OPER;
            VIEW_BACK_KEY_MAIN:  display <= VIEW_BACK_KEY_OPER;
            VIEW_BACK_KEY_SUB:   display <= VIEW_BACK_KEY_MAIN;
            VIEW_BACK_KEY_PARAM: display <= VIEW_BACK_KEY_SUB;
            VIEW_BACK_KEY_MODE:  display <= VIEW_BACK_KEY_OPER;
         endcase
      end else if (press[KEY_MODE] && in_oper) begin
         display <= VIEW_BACK_KEY_MODE;
      end else if (reg_short) begin
         unique case (display)
            VIEW_BACK_KEY_MAIN:  display <= VIEW_BACK_KEY_SUB;
            VIEW_BACK_KEY_SUB:   display <= VIEW_BACK_KEY_PARAM;
            VIEW_BACK_KEY_MODE:  display <= VIEW_BACK_KEY_OPER;
            VIEW_BACK_KEY_OPER:  display <= VIEW_BACK_KEY_OPER;
            VIEW_BACK_KEY_PARAM: display <= VIEW_BACK_KEY_PARAM;
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         oper_view <= 8'h00;
      end else if (press[KEY_VIEW] && in_oper && !reg_long) begin
         oper_view <= (oper_view == 8'(NUM_VIEWS - 1)) ? 8'h00 : oper_view + 8'h01;
      end
   end

   // menu index wraps both ways; steps only while a menu is shown
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         menu_index <= 8'h00;
      end else if (rep_step && (display == VIEW_BACK_KEY_MAIN || display == VIEW_BACK_KEY_SUB)) begin
         if (up_only) begin
            menu_index <= (menu_index == 8'(NUM_MENUS - 1)) ? 8'h00 : menu_index + 8'h01;
         end else begin
            menu_index <= (menu_index == 8'h00) ? 8'(NUM_MENUS - 1) : menu_index - 8'h01;
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mode_choice <= MODE_HOLD;
      end else if (rep_step && display == VIEW_BACK_KEY_MODE) begin
         if (up_only) begin
            mode_choice <= (mode_choice == MODE_MANUAL) ? MODE_HOLD
                           : fpkl_mode_e'(mode_choice + 3'h1);
         end else begin
            mode_choice <= (mode_choice == MODE_HOLD) ? MODE_MANUAL
                           : fpkl_mode_e'(mode_choice - 3'h1);
         end
      end
   end

   // action pulses, one cycle each
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         actions <= '0;
      end else begin
         actions.start_pulse        <= run_long && in_oper;
         actions.stop_pulse         <= rst_long && in_oper;
         actions.param_switch_pulse <= reg_short && in_oper;
         actions.param_commit_pulse <= reg_short && display == VIEW_BACK_KEY_PARAM;
         actions.value_inc_pulse    <= rep_step && up_only && display == VIEW_BACK_KEY_PARAM;
         actions.value_dec_pulse    <= rep_step && down_only && display == VIEW_BACK_KEY_PARAM;
         actions.pattern_step_pulse <= press[KEY_PAT] && in_oper && !status.running;
         actions.mode_commit_pulse  <= reg_short && display == VIEW_BACK_KEY_MODE;
      end
   end

   // lamps are registered so they never glitch on status changes
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         lamps <= '0;
      end else begin
         lamps.rising_lamp  <= status.trend == TREND_RISE;
         lamps.falling_lamp <= status.trend == TREND_FALL;
         // an undefined trend code shows level, keeping one lamp lit
         lamps.level_lamp   <= status.trend != TREND_RISE && status.trend != TREND_FALL;
         lamps.process_event_one_lamp <= status.pv_event[0];
         lamps.process_event_two_lamp <= status.pv_event[1];
         lamps.timed_event_lamp       <= status.time_event;
         lamps.alarm_one_lamp         <= status.alarm_one;
         lamps.program_mode_lamp      <= status.program_mode;
         lamps.reset_mode_lamp        <= status.reset_mode;
         lamps.hold_mode_lamp         <= status.hold_mode;
         lamps.internal_sp_lamp       <= status.local_mode;
         lamps.manual_mode_lamp       <= status.manual_mode;
         lamps.second_pv_lamp         <= 1'b0;
         lamps.second_manual_lamp     <= 1'b0;
         lamps.secondary_link_lamp    <= 1'b0;
         lamps.pv_error_red           <= status.error_active;
      end
   end

   sequence run_held_s;
      run_long && in_oper;
   endsequence
   sequence rst_held_s;
      rst_long && in_oper;
   endsequence

   trend_one_hot_a: assert property (@(posedge clock) disable iff (rst)
      $past(!rst) |-> $onehot({lamps.rising_lamp, lamps.level_lamp, lamps.falling_lamp}))
      else $error("trend lamps not one-hot");
   trend_follow_a: assert property (@(posedge clock) disable iff (rst)
      status.trend == TREND_RISE |=> lamps.rising_lamp)
      else $error("rising lamp missing");
   events_follow_a: assert property (@(posedge clock) disable iff (rst)
      ##1 ({lamps.process_event_two_lamp, lamps.process_event_one_lamp}
           == $past(status.pv_event)) && lamps.timed_event_lamp == $past(status.time_event))
      else $error("event lamps wrong");
   alarm_follow_a: assert property (@(posedge clock) disable iff (rst)
      $fell(status.alarm_one) |=> !lamps.alarm_one_lamp)
      else $error("alarm lamp stuck");
   mode_lamps_a: assert property (@(posedge clock) disable iff (rst)
      status.manual_mode && status.hold_mode |=> lamps.manual_mode_lamp && lamps.hold_mode_lamp)
      else $error("status lamps wrong");
   unused_lamps_a: assert property (@(posedge clock) disable iff (rst)
      !(lamps.second_pv_lamp || lamps.second_manual_lamp || lamps.secondary_link_lamp))
      else $error("unused lamp lit");
   error_red_a: assert property (@(posedge clock) disable iff (rst)
      status.error_active |=> lamps.pv_error_red)
      else $error("error code not shown");
   menu_toggle_a: assert property (@(posedge clock) disable iff (rst)
      reg_long && in_oper |=> display == VIEW_BACK_KEY_MAIN)
      else $error("long register press did not open menu");
   back_step_a: assert property (@(posedge clock) disable iff (rst)
      press[KEY_VIEW] && !reg_long && display == VIEW_BACK_KEY_PARAM |=> display == VIEW_BACK_KEY_SUB)
      else $error("view back not one step");
   back_bound_a: assert property (@(posedge clock) disable iff (rst)
      press[KEY_VIEW] && !reg_long |=> display != VIEW_BACK_KEY_PARAM && display != VIEW_BACK_KEY_MODE)
      else $error("view back too slow");
   value_step_a: assert property (@(posedge clock) disable iff (rst)
      press[KEY_DOWN] && !key_down[KEY_UP] && display == VIEW_BACK_KEY_PARAM
      |=> actions.value_dec_pulse && !actions.value_inc_pulse)
      else $error("down key did not decrement");
   repeat_floor_a: assert property (@(posedge clock) disable iff (rst)
      rep_interval_reg >= 32'(REP_FAST_CYC) && rep_interval_reg <= 32'(REP_SLOW_CYC))
      else $error("repeat interval out of range");
   menu_no_value_a: assert property (@(posedge clock) disable iff (rst)
      display == VIEW_BACK_KEY_MAIN |=> !actions.value_inc_pulse && !actions.value_dec_pulse)
      else $error("menu changed a value");
   pattern_gate_a: assert property (@(posedge clock) disable iff (rst)
      press[KEY_PAT] && (status.running || !in_oper) |=> !actions.pattern_step_pulse)
      else $error("pattern key accepted while running");
   start_fire_a: assert property (@(posedge clock) disable iff (rst)
      run_held_s |=> actions.start_pulse ##1 !actions.start_pulse [*8])
      else $error("start not single pulse");
   stop_fire_a: assert property (@(posedge clock) disable iff (rst)
      rst_held_s |=> actions.stop_pulse ##1 !actions.stop_pulse [*8])
      else $error("stop not single pulse");
   start_gate_a: assert property (@(posedge clock) disable iff (rst)
      actions.start_pulse |-> $past(run_long) && $past(in_oper))
      else $error("start without long press");
   stop_gate_a: assert property (@(posedge clock) disable iff (rst)
      actions.stop_pulse |-> $past(rst_long) && $past(in_oper))
      else $error("stop without long press");
   menu_return_a: assert property (@(posedge clock) disable iff (rst)
      reg_long && !in_oper |=> display == VIEW_BACK_KEY_OPER)
      else $error("long register press did not return");
   commit_single_a: assert property (@(posedge clock) disable iff (rst)
      actions.param_commit_pulse |=> !actions.param_commit_pulse)
      else $error("commit pulse too long");
   long_once_a: assert property (@(posedge clock) disable iff (rst)
      reg_long |=> !reg_long [*8])
      else $error("long press fired twice");
   view_cycle_a: assert property (@(posedge clock) disable iff (rst)
      press[KEY_VIEW] && in_oper && !reg_long
      |=> display == VIEW_BACK_KEY_OPER && oper_view != $past(oper_view))
      else $error("operating view did not advance");
   mode_open_a: assert property (@(posedge clock) disable iff (rst)
      press[KEY_MODE] && in_oper && !press[KEY_VIEW] && !reg_long |=> display == VIEW_BACK_KEY_MODE)
      else $error("mode key did not open selection");
   mode_step_a: assert property (@(posedge clock) disable iff (rst)
      rep_step && up_only && display == VIEW_BACK_KEY_MODE |=> mode_choice != $past(mode_choice))
      else $error("mode choice did not step");
   menu_step_a: assert property (@(posedge clock) disable iff (rst)
      rep_step && up_only && display == VIEW_BACK_KEY_MAIN |=> menu_index != $past(menu_index))
      else $error("menu did not step");
   up_step_a: assert property (@(posedge clock) disable iff (rst)
      press[KEY_UP] && !key_down[KEY_DOWN] && display == VIEW_BACK_KEY_PARAM
      |=> actions.value_inc_pulse && !actions.value_dec_pulse)
      else $error("up key did not increment");
   both_keys_a: assert property (@(posedge clock) disable iff (rst)
      key_down[KEY_UP] && key_down[KEY_DOWN]
      |=> !actions.value_inc_pulse && !actions.value_dec_pulse)
      else $error("up and down together changed a value");
   pattern_accept_a: assert property (@(posedge clock) disable iff (rst)
      press[KEY_PAT] && in_oper && !status.running |=> actions.pattern_step_pulse)
      else $error("pattern key not accepted");
   alarm_on_a: assert property (@(posedge clock) disable iff (rst)
      status.alarm_one |=> lamps.alarm_one_lamp)
      else $error("alarm lamp not lit");
   level_lamp_a: assert property (@(posedge clock) disable iff (rst)
      status.trend == TREND_LEVEL |=> lamps.level_lamp && !lamps.rising_lamp)
      else $error("level lamp missing");
endmodule // fpkl_panel

// file: dv/fpkl_operator.sv
`timescale 1ns/1ps
module fpkl_operator
   import fpkl_pkg::*;
(
   input  wire logic                clock,
   output logic [NUM_KEYS-1:0]      keys_raw
);
   initial keys_raw = '0;

   // contact chatters once before settling, so the debouncer is exercised
   task automatic hold_key(int k);
      logic [NUM_KEYS-1:0] m;
      m = NUM_KEYS'(1) << k;
      @(posedge clock) keys_raw <= keys_raw | m;
      @(posedge clock) keys_raw <= keys_raw & ~m;
      @(posedge clock) keys_raw <= keys_raw | m;
   endtask

   // idle long enough for sync, debounce and the release action to land
   task automatic release_key(int k);
      logic [NUM_KEYS-1:0] m;
      m = NUM_KEYS'(1) << k;
      @(posedge clock) keys_raw <= keys_raw & ~m;
      repeat (12) @(posedge clock);
   endtask

   task automatic press(int k, int n);
      hold_key(k);
      repeat (n) @(posedge clock);
      release_key(k);
   endtask
endmodule // fpkl_operator

// file: dv/tb_front_panel_key_lamp_control.sv
`timescale 1ns/1ps
module tb_front_panel_key_lamp_control
   import fpkl_pkg::*;
;
   localparam int A_START = 7;
   localparam int A_STOP  = 6;
   localparam int A_SW    = 5;
   localparam int A_CMT   = 4;
   localparam int A_INC   = 3;
   localparam int A_DEC   = 2;
   localparam int A_PAT   = 1;
   localparam int A_MODE  = 0;

   logic                clock = 1'b0;
   logic                rst   = 1'b1;
   logic [NUM_KEYS-1:0] keys_raw;
   fpkl_status_s        st    = '0;
   fpkl_lamps_s         lamps;
   fpkl_lamps_s         exp_l;
   fpkl_action_s        actions;
   fpkl_view_back_key_e          view_back_key;
   logic [7:0]          oper_view;
   logic [7:0]          menu_index;
   fpkl_mode_e          mode_choice;
   int                  fails = 0;
   int                  samples_checked = 0;
   int                  cnt[8] = '{default: 0};
   int                  snap[8];
   int                  w1;
   int                  w2;
   int                  n;

   always #12.5 clock = ~clock;

   fpkl_operator op (.clock(clock), .keys_raw(keys_raw));

   // run threshold and fast repeat rate follow from these by their fixed ratios
   fpkl_panel #(.DEB_CYC(4), .REG_LONG_CYC(60), .REP_START_CYC(20), .REP_SLOW_CYC(16)) uut (
      .clock(clock), .rst(rst), .keys_raw(keys_raw), .status(st), .lamps(lamps),
      .actions(actions), .display(view_back_key), .oper_view(oper_view), .menu_index(menu_index),
      .mode_choice(mode_choice));

   always @(posedge clock) begin
      for (int i = 0; i < 8; i++) if (actions[i] === 1'b1) cnt[i] <= cnt[i] + 1;
   end

   task automatic chk(logic [31:0] got, logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // pulses are judged by difference, so no second driver clears the counters
   task automatic go(int k, int hold);
      snap = cnt;
      op.press(k, hold);
   endtask

   function automatic int d(int a);
      return cnt[a] - snap[a];
   endfunction

   task automatic finish_test();
      $display("checks %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clock);
      fails++;
      finish_test();
   end

   initial begin
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         @(posedge clock) begin
            st.trend <= 2'(i); st.pv_event <= 2'(i); st.time_event <= 4'h1 << i;
            st.alarm_one <= i[0]; st.program_mode <= (i == 0); st.reset_mode <= (i == 1);
            st.hold_mode <= (i == 2); st.local_mode <= (i == 3); st.manual_mode <= i[1];
            st.error_active <= i[0] ^ i[1];
         end
         repeat (3) @(posedge clock);
         exp_l = '0;
         exp_l.rising_lamp = (i == 0); exp_l.level_lamp = (i == 1 || i == 3);
         exp_l.falling_lamp = (i == 2);
         exp_l.process_event_one_lamp = i[0]; exp_l.process_event_two_lamp = i[1];
         exp_l.timed_event_lamp = 4'h1 << i; exp_l.alarm_one_lamp = i[0];
         exp_l.program_mode_lamp = (i == 0); exp_l.reset_mode_lamp = (i == 1);
         exp_l.hold_mode_lamp = (i == 2); exp_l.internal_sp_lamp = (i == 3);
         exp_l.manual_mode_lamp = i[1]; exp_l.pv_error_red = i[0] ^ i[1];
         chk(32'(lamps), 32'(exp_l));
      end
      @(posedge clock) st <= '0;
      go(KEY_RUN, 60);  chk(d(A_START), 1);
      go(KEY_RUN, 20);  chk(d(A_START), 0);
      go(KEY_RST, 60);  chk(d(A_STOP), 1);
      go(KEY_PAT, 15);  chk(d(A_PAT), 1);
      @(posedge clock) st.running <= 1'b1;
      go(KEY_PAT, 15);  chk(d(A_PAT), 0);
      @(posedge clock) st.running <= 1'b0;
      go(KEY_VIEW, 15); chk(oper_view, 1);
      go(KEY_REG, 15);  chk(d(A_SW), 1);
      go(KEY_REG, 80);  chk(view_back_key, VIEW_BACK_KEY_MAIN);
      chk(d(A_SW), 0);
      go(KEY_RUN, 60);  chk(d(A_START), 0);
      go(KEY_UP, 15);   chk(menu_index, 1);
      chk(d(A_INC), 0);
      go(KEY_DOWN, 15); chk(menu_index, 0);
      go(KEY_DOWN, 15); chk(menu_index, 7);
      go(KEY_REG, 15);  chk(view_back_key, VIEW_BACK_KEY_SUB);
      go(KEY_REG, 15);  chk(view_back_key, VIEW_BACK_KEY_PARAM);
      go(KEY_UP, 15);   chk(d(A_INC), 1);
      go(KEY_DOWN, 15); chk(d(A_DEC), 1);
      go(KEY_REG, 15);  chk(d(A_CMT), 1);
      // held key: change rate over a later window must beat an earlier one
      snap = cnt;
      op.hold_key(KEY_UP);
      n = 0;
      while (cnt[A_INC] == snap[A_INC] && n < 60) begin
         @(posedge clock);
         n++;
      end
      repeat (40) @(posedge clock);
      w1 = cnt[A_INC];
      repeat (100) @(posedge clock);
      w2 = cnt[A_INC];
      w1 = w2 - w1;
      repeat (100) @(posedge clock);
      w2 = cnt[A_INC] - w2;
      op.release_key(KEY_UP);
      chk(32'(w1 > 0 && w2 > w1), 1);
      go(KEY_VIEW, 15); chk(view_back_key, VIEW_BACK_KEY_SUB);
      go(KEY_VIEW, 15); chk(view_back_key, VIEW_BACK_KEY_MAIN);
      go(KEY_VIEW, 15); chk(view_back_key, VIEW_BACK_KEY_OPER);
      go(KEY_MODE, 15); chk(view_back_key, VIEW_BACK_KEY_MODE);
      go(KEY_UP, 15);   chk(mode_choice, MODE_ADVANCE);
      go(KEY_REG, 15);  chk(d(A_MODE), 1);
      chk(view_back_key, VIEW_BACK_KEY_OPER);
      go(KEY_REG, 80);  chk(view_back_key, VIEW_BACK_KEY_MAIN);
      go(KEY_REG, 80);  chk(view_back_key, VIEW_BACK_KEY_OPER);
      finish_test();
   end
endmodule // tb_front_panel_key_lamp_control
